// ### hw/tcv_defs.svh
// Register indices and reset values for the timer channel value block.
// Assumes byte address = 4 * index on a 32-bit APB.
`ifndef TCV_DEFS_SVH
`define TCV_DEFS_SVH
`define TCV_CH0_HIGH_IDX 8'h27
`define TCV_CH0_LOW_IDX  8'h28
`define TCV_CH1_HIGH_IDX 8'h2A
`define TCV_CH1_LOW_IDX  8'h2B
`define TCV_CH2_HIGH_IDX 8'h2D
`define TCV_CH2_LOW_IDX  8'h2E
`define TCV_CH3_HIGH_IDX 8'h30
`define TCV_CH3_LOW_IDX  8'h31
`define TCV_CH4_HIGH_IDX 8'h33
`define TCV_CH4_LOW_IDX  8'h34
`define TCV_CH5_HIGH_IDX 8'h36
`define TCV_CH5_LOW_IDX  8'h37
`define TCV_CTRL_BASE_IDX 8'h40
`define TCV_STATUS_IDX   8'h48
`define TCV_MASK_IDX     8'h49
`define TCV_CTRL_RST     4'h0
`define TCV_FLAG_RST     6'h00
`define TCV_MASK_RST     6'h00
`endif

// ### hw/tcv_pkg.sv
// Types shared by the timer channel value block.
// Assumes tcv_defs.svh for all numbers.
package tcv_pkg;
    typedef enum logic [2:0] {
        TCV_REG_NONE,
        TCV_REG_HIGH,
        TCV_REG_LOW,
        TCV_REG_CTRL,
        TCV_REG_STATUS,
        TCV_REG_MASK
    } tcv_kind_t;

    typedef struct packed {
        tcv_kind_t  kind;
        logic [2:0] ch;
    } tcv_dec_t;

    typedef struct packed {
        logic buffered_mode_select;
        logic unbuffered_mode_select;
        logic overflow_toggle_enable;
        logic max_duty_force;
    } tcv_ctrl_t;

    typedef struct packed {
        logic [5:0][15:0] value;
        tcv_ctrl_t [5:0]  ctrl;
        logic [5:0]       flag;
        logic [5:0]       mask;
        logic [5:0]       cap_lock;
        logic [5:0]       cmp_lock;
        logic [5:0]       max_eff;
        logic [5:0]       chan_out;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
        logic             irq;
    } tcv_state_t;
endpackage : tcv_pkg

// ### hw/tcv_timer_channel_value_regs.sv
// Six-channel 16-bit capture/compare value registers with APB access.
// Assumes counter, overflow and qualified capture edges on this clock.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "tcv_defs.svh"

// Contract
// - Max duty force gives full duty output; the code forces it only while toggle enable is clear
// - Max duty change applies next period
// - Value registers readable, writable, hold values
// - Value registers are not reset
// - Capture: high read blocks captures until low
// - Compare: high write blocks matches until low
// - High byte bits 15-8, low 7-0
// - Flag on capture or counter match
// - Toggle enable toggles output on overflow
module tcv_timer_channel_value_regs (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] counter_value,
    input  wire logic        counter_overflow,
    input  wire logic [5:0]  capture_edge,
    output logic      [5:0]  chan_out,
    output logic             irq
);
    import tcv_pkg::*;

    localparam int NCH = 6;
    localparam logic [5:0][7:0] HIGH_IDX = {
        `TCV_CH5_HIGH_IDX, `TCV_CH4_HIGH_IDX, `TCV_CH3_HIGH_IDX,
        `TCV_CH2_HIGH_IDX, `TCV_CH1_HIGH_IDX, `TCV_CH0_HIGH_IDX};
    localparam logic [5:0][7:0] LOW_IDX = {
        `TCV_CH5_LOW_IDX, `TCV_CH4_LOW_IDX, `TCV_CH3_LOW_IDX,
        `TCV_CH2_LOW_IDX, `TCV_CH1_LOW_IDX, `TCV_CH0_LOW_IDX};

    tcv_state_t st_q;
    tcv_state_t st_d;
    tcv_dec_t   dec;
    logic       apb_wr;
    logic       apb_rd;
    logic       apb_setup;
    logic [7:0] rd_byte;
    logic [5:0] cap_fire;
    logic [5:0] cmp_hit;

    function automatic tcv_dec_t decode(input logic [11:0] a);
        tcv_dec_t r;
        r.kind = TCV_REG_NONE;
        r.ch   = 3'h0;
        if (a[1:0] == 2'h0 && a[11:10] == 2'h0) begin
            for (int i = 0; i < NCH; i++) begin
                if (a[9:2] == HIGH_IDX[i]) begin
                    r.kind = TCV_REG_HIGH;
                    r.ch   = 3'(i);
                end
                if (a[9:2] == LOW_IDX[i]) begin
                    r.kind = TCV_REG_LOW;
                    r.ch   = 3'(i);
                end
                if (a[9:2] == `TCV_CTRL_BASE_IDX + 8'(i)) begin
                    r.kind = TCV_REG_CTRL;
                    r.ch   = 3'(i);
                end
            end
            if (a[9:2] == `TCV_STATUS_IDX) begin
                r.kind = TCV_REG_STATUS;
            end
            if (a[9:2] == `TCV_MASK_IDX) begin
                r.kind = TCV_REG_MASK;
            end
        end
        return r;
    endfunction : decode

    // Capture mode means both mode select bits clear
    function automatic logic cap_mode(input tcv_ctrl_t c);
        return !c.buffered_mode_select && !c.unbuffered_mode_select;
    endfunction : cap_mode

    assign dec       = decode(paddr);
    assign apb_setup = psel && penable && !st_q.pready;
    assign apb_wr    = psel && penable && st_q.pready && pwrite;
    assign apb_rd    = psel && penable && st_q.pready && !pwrite;

    // Locks gate events; bus side effects land at the completion edge
    for (genvar g = 0; g < NCH; g++) begin : g_evt
        assign cap_fire[g] = capture_edge[g] && cap_mode(st_q.ctrl[g])
                             && !st_q.cap_lock[g];
        assign cmp_hit[g]  = !cap_mode(st_q.ctrl[g])
                             && !st_q.cmp_lock[g]
                             && counter_value == st_q.value[g];
    end

    always_comb begin
        rd_byte = 8'h00;
        case (dec.kind)
            TCV_REG_HIGH:   rd_byte = st_q.value[dec.ch][15:8];
            TCV_REG_LOW:    rd_byte = st_q.value[dec.ch][7:0];
            TCV_REG_CTRL:   rd_byte = {4'h0, st_q.ctrl[dec.ch]};
            TCV_REG_STATUS: rd_byte = {2'h0, st_q.flag};
            TCV_REG_MASK:   rd_byte = {2'h0, st_q.mask};
            default:        rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        st_d         = st_q;
        // One wait state: ready rises on the second access cycle
        st_d.pready  = apb_setup;
        st_d.pslverr = apb_setup && dec.kind == TCV_REG_NONE;
        if (apb_setup) begin
            st_d.prdata = {24'h000000, rd_byte};
        end
        if (apb_wr || apb_rd) begin
            case (dec.kind)
                TCV_REG_HIGH: begin
                    if (apb_wr) begin
                        st_d.value[dec.ch][15:8] = pwdata[7:0];
                        if (!cap_mode(st_q.ctrl[dec.ch])) begin
                            st_d.cmp_lock[dec.ch] = 1'b1;
                        end
                    end else if (cap_mode(st_q.ctrl[dec.ch])) begin
                        st_d.cap_lock[dec.ch] = 1'b1;
                    end
                end
                TCV_REG_LOW: begin
                    if (apb_wr) begin
                        st_d.value[dec.ch][7:0] = pwdata[7:0];
                        st_d.cmp_lock[dec.ch]   = 1'b0;
                    end else begin
                        st_d.cap_lock[dec.ch] = 1'b0;
                    end
                end
                TCV_REG_CTRL: begin
                    if (apb_wr) begin
                        st_d.ctrl[dec.ch] = pwdata[3:0];
                        // Buffered select exists on even channels only
                        if (dec.ch[0]) begin
                            st_d.ctrl[dec.ch].buffered_mode_select = 1'b0;
                        end
                    end
                end
                TCV_REG_STATUS: begin
                    if (apb_wr) begin
                        st_d.flag = st_q.flag & ~pwdata[5:0];
                    end
                end
                TCV_REG_MASK: begin
                    if (apb_wr) begin
                        st_d.mask = pwdata[5:0];
                    end
                end
                default: begin
                end
            endcase
        end
        for (int i = 0; i < NCH; i++) begin
            // Capture beats a same-cycle bus write, and set beats clear
            if (cap_fire[i]) begin
                st_d.value[i] = counter_value;
                st_d.flag[i]  = 1'b1;
            end
            if (cmp_hit[i]) begin
                st_d.flag[i] = 1'b1;
            end
            // Period boundary is the counter overflow
            if (counter_overflow) begin
                st_d.max_eff[i] = st_q.ctrl[i].max_duty_force;
            end
            if (!cap_mode(st_q.ctrl[i])) begin
                if (counter_overflow
                    && st_q.ctrl[i].overflow_toggle_enable) begin
                    st_d.chan_out[i] = !st_q.chan_out[i];
                end else if (counter_overflow) begin
                    st_d.chan_out[i] = 1'b1;
                end else if (cmp_hit[i]) begin
                    st_d.chan_out[i] = 1'b0;
                end
                if (st_d.max_eff[i]
                    && !st_d.ctrl[i].overflow_toggle_enable) begin
                    st_d.chan_out[i] = 1'b1;
                end
            end
        end
        st_d.irq = |(st_d.flag & st_d.mask);
    end

    // Values are left out of reset on purpose: no defined content
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q.ctrl     <= {NCH{`TCV_CTRL_RST}};
            st_q.flag     <= `TCV_FLAG_RST;
            st_q.mask     <= `TCV_MASK_RST;
            st_q.cap_lock <= 6'h00;
            st_q.cmp_lock <= 6'h00;
            st_q.max_eff  <= 6'h00;
            st_q.chan_out <= 6'h00;
            st_q.pready   <= 1'b0;
            st_q.pslverr  <= 1'b0;
            st_q.prdata   <= 32'h00000000;
            st_q.irq      <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata   = st_q.prdata;
    assign pready   = st_q.pready;
    assign pslverr  = st_q.pslverr;
    assign chan_out = st_q.chan_out;
    assign irq      = st_q.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_irq_level;
        irq == |(st_q.flag & st_q.mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("irq does not follow masked flags");

    for (genvar g = 0; g < NCH; g++) begin : g_chk
        property p_max_duty;
            st_q.max_eff[g] && !st_q.ctrl[g].overflow_toggle_enable
                && !cap_mode(st_q.ctrl[g]) |-> chan_out[g];
        endproperty
        a_max_duty: assert property (p_max_duty)
            else $error("full duty not forced");

        property p_max_latency;
            !counter_overflow |=> $stable(st_q.max_eff[g]);
        endproperty
        a_max_latency: assert property (p_max_latency)
            else $error("max duty changed inside a period");

        property p_max_load;
            counter_overflow
                |=> st_q.max_eff[g] == $past(st_q.ctrl[g].max_duty_force);
        endproperty
        a_max_load: assert property (p_max_load)
            else $error("max duty not loaded at period start");

        sequence s_high_write;
            apb_wr && dec.kind == TCV_REG_HIGH && dec.ch == 3'(g)
                && !cap_fire[g];
        endsequence
        property p_high_write;
            s_high_write
                |=> st_q.value[g][15:8] == $past(pwdata[7:0]);
        endproperty
        a_high_write: assert property (p_high_write)
            else $error("high byte write lost");

        property p_cap_block;
            st_q.cap_lock[g] && !apb_wr |=> $stable(st_q.value[g]);
        endproperty
        a_cap_block: assert property (p_cap_block)
            else $error("capture while high byte read pending");

        property p_cmp_block;
            st_q.cmp_lock[g] && !cap_mode(st_q.ctrl[g])
                && !cap_fire[g] && !st_q.flag[g] |=> !st_q.flag[g];
        endproperty
        a_cmp_block: assert property (p_cmp_block)
            else $error("compare flag while high byte write pending");

        property p_cmp_flag;
            cmp_hit[g] |=> st_q.flag[g];
        endproperty
        a_cmp_flag: assert property (p_cmp_flag)
            else $error("compare match did not set flag");

        property p_toggle;
            counter_overflow && st_q.ctrl[g].overflow_toggle_enable
                && !cap_mode(st_q.ctrl[g])
                |=> chan_out[g] == !$past(chan_out[g]);
        endproperty
        a_toggle: assert property (p_toggle)
            else $error("output did not toggle on overflow");

        property p_capture;
            cap_fire[g] |=> st_q.value[g] == $past(counter_value)
                && st_q.flag[g];
        endproperty
        a_capture: assert property (p_capture)
            else $error("capture did not copy counter");
    end
endmodule : tcv_timer_channel_value_regs
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the timer channel value block.
// Assumes one APB wait state and single-cycle event pulses.
`timescale 1ns/1ps
`default_nettype none
`include "tcv_defs.svh"
module tb;
    import tcv_pkg::*;
    logic        clk;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] counter_value;
    logic        counter_overflow;
    logic [5:0]  capture_edge;
    logic [5:0]  chan_out;
    logic        irq;
    int          errors;
    int          compares;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  hi_idx [6] = '{`TCV_CH0_HIGH_IDX, `TCV_CH1_HIGH_IDX,
        `TCV_CH2_HIGH_IDX, `TCV_CH3_HIGH_IDX, `TCV_CH4_HIGH_IDX,
        `TCV_CH5_HIGH_IDX};

    tcv_timer_channel_value_regs tcv_timer_channel_value_regs_inst (
        .clk              (clk),
        .reset            (reset),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .counter_value    (counter_value),
        .counter_overflow (counter_overflow),
        .capture_edge     (capture_edge),
        .chan_out         (chan_out),
        .irq              (irq)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("Compares %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Ready sampled at the rising edge that completes the transfer
    // Returns on the falling edge so outputs have settled
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                errors++;
                report_and_stop();
            end
            @(posedge clk);
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        check(rd, exp);
    endtask : rdchk

    // Upper data bits set on purpose; only the byte may land
    task automatic setv(input int ch, input logic [15:0] v);
        wr(hi_idx[ch], {24'hFFFFFF, v[15:8]});
        wr(hi_idx[ch] + 8'h01, {24'hFFFFFF, v[7:0]});
    endtask : setv

    task automatic cap(input int ch, input logic [15:0] v);
        @(posedge clk);
        counter_value <= v;
        capture_edge  <= 6'h01 << ch;
        @(posedge clk);
        counter_value <= 16'hFFFF;
        capture_edge  <= 6'h00;
        @(negedge clk);
    endtask : cap

    task automatic hit(input logic [15:0] v);
        @(posedge clk);
        counter_value <= v;
        @(posedge clk);
        counter_value <= 16'hFFFF;
        @(negedge clk);
    endtask : hit

    task automatic ovf();
        @(posedge clk);
        counter_overflow <= 1'b1;
        @(posedge clk);
        counter_overflow <= 1'b0;
        @(negedge clk);
    endtask : ovf

    task automatic t_reset();
        check(chan_out, 6'h00);
        check(irq, 1'b0);
        rdchk(`TCV_CTRL_BASE_IDX, 32'h0);
        rdchk(`TCV_STATUS_IDX, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        $display("reset and unmapped test done");
    endtask : t_reset

    task automatic t_regs();
        logic [15:0] v;
        for (int ch = 0; ch < 6; ch++) begin
            v = {4'hA, ch[3:0], 4'h5, ~ch[3:0]};
            setv(ch, v);
            rdchk(hi_idx[ch], {24'h0, v[15:8]});
            rdchk(hi_idx[ch] + 8'h01, {24'h0, v[7:0]});
        end
        $display("value register test done");
    endtask : t_regs

    task automatic t_capture();
        wr(`TCV_MASK_IDX, 32'h01);
        cap(0, 16'h1234);
        check(irq, 1'b1);
        rdchk(`TCV_STATUS_IDX, 32'h01);
        rdchk(hi_idx[0], 32'h12);
        rdchk(hi_idx[0] + 8'h01, 32'h34);
        wr(`TCV_STATUS_IDX, 32'h01);
        check(irq, 1'b0);
        rdchk(hi_idx[0], 32'h12);
        cap(0, 16'hABCD);
        rdchk(hi_idx[0] + 8'h01, 32'h34);
        wr(`TCV_MASK_IDX, 32'h00);
        cap(0, 16'hABCD);
        check(irq, 1'b0);
        rdchk(hi_idx[0], 32'hAB);
        rdchk(hi_idx[0] + 8'h01, 32'hCD);
        wr(`TCV_STATUS_IDX, 32'h3F);
        $display("capture test done");
    endtask : t_capture

    task automatic t_compare();
        wr(`TCV_CTRL_BASE_IDX + 8'h01, 32'h04);
        setv(1, 16'h0050);
        hit(16'h0050);
        rdchk(`TCV_STATUS_IDX, 32'h02);
        wr(`TCV_STATUS_IDX, 32'h02);
        wr(hi_idx[1], 32'h00);
        hit(16'h0050);
        rdchk(`TCV_STATUS_IDX, 32'h00);
        wr(hi_idx[1] + 8'h01, 32'h50);
        hit(16'h0050);
        rdchk(`TCV_STATUS_IDX, 32'h02);
        wr(`TCV_STATUS_IDX, 32'h3F);
        $display("compare test done");
    endtask : t_compare

    task automatic t_pwm();
        setv(2, 16'h0010);
        wr(`TCV_CTRL_BASE_IDX + 8'h02, 32'h04);
        ovf();
        check(chan_out[2], 1'b1);
        hit(16'h0010);
        check(chan_out[2], 1'b0);
        wr(`TCV_CTRL_BASE_IDX + 8'h02, 32'h05);
        check(chan_out[2], 1'b0);
        ovf();
        check(chan_out[2], 1'b1);
        hit(16'h0010);
        check(chan_out[2], 1'b1);
        wr(`TCV_CTRL_BASE_IDX + 8'h02, 32'h04);
        hit(16'h0010);
        check(chan_out[2], 1'b1);
        ovf();
        hit(16'h0010);
        check(chan_out[2], 1'b0);
        // Toggle enabled: forcing must not apply
        setv(3, 16'h0020);
        wr(`TCV_CTRL_BASE_IDX + 8'h03, 32'h07);
        check(chan_out[3], 1'b0);
        ovf();
        check(chan_out[3], 1'b1);
        ovf();
        check(chan_out[3], 1'b0);
        $display("output test done");
    endtask : t_pwm

    initial begin
        errors           = 0;
        compares         = 0;
        reset            = 1'b1;
        psel             = 1'b0;
        penable          = 1'b0;
        pwrite           = 1'b0;
        paddr            = 12'h000;
        pwdata           = 32'h0;
        counter_value    = 16'hFFFF;
        counter_overflow = 1'b0;
        capture_edge     = 6'h00;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        t_reset();
        t_regs();
        t_capture();
        t_compare();
        t_pwm();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
